/* File: hw/lcdie_defines.svh */
// Constants of the LCD instruction executor: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef LCDIE_DEFINES_SVH
`define LCDIE_DEFINES_SVH
// ==========================================================================
// Register offsets (byte addresses on the APB slave)
`define LCDIE_OFS_INSTR 12'h000
`define LCDIE_OFS_DATA 12'h004
`define LCDIE_OFS_CTRL 12'h008
`define LCDIE_OFS_MODE 12'h00C
// ==========================================================================
// Control register fields
`define LCDIE_CTRL_SERIAL 0
`define LCDIE_CTRL_PULLUP 1
// ==========================================================================
// Mode register fields (read only)
`define LCDIE_MODE_WIDTH 0
`define LCDIE_MODE_LINES 1
`define LCDIE_MODE_SINGLE 2
`define LCDIE_MODE_EXT 3
`define LCDIE_MODE_STEP 4
`define LCDIE_MODE_BLINK 5
`define LCDIE_MODE_ICONF 6
`define LCDIE_MODE_PHASE 7
`define LCDIE_MODE_GLYPH 8
// ==========================================================================
// Instruction fields
`define LCDIE_FS_WIDTH 4
`define LCDIE_FS_LINES 2
`define LCDIE_FS_SINGLE 1
`define LCDIE_FS_EXT 0
`define LCDIE_SH_DISP 3
`define LCDIE_SH_RIGHT 2
`define LCDIE_EM_STEP 1
`define LCDIE_DC_BLINK 0
`define LCDIE_IC_ICONF 1
// ==========================================================================
// Reset values
`define LCDIE_RST_WIDTH 1'b1
`define LCDIE_RST_STEP 1'b1
`define LCDIE_RST_TEXT 8'h20
// ==========================================================================
// Address map of the text RAM and icon storage, and row enable patterns
`define LCDIE_L1_END 7'h27
`define LCDIE_L2_START 7'h40
`define LCDIE_L2_END 7'h67
`define LCDIE_ONE_END 7'h4F
`define LCDIE_LINE_LEN 7'd40
`define LCDIE_RAM_LEN 7'd80
`define LCDIE_ODD_BASE 7'h20
`define LCDIE_ROWS_ALL 18'h3FFFF
`define LCDIE_ROWS_MUX9 18'h100FF
// ==========================================================================
// Timing counts in oscillator cycles
`define LCDIE_EXEC_CYC 4'h4
`define LCDIE_BLINK_DIV 104448
`endif

/* File: hw/lcdie_pkg.sv */
// Types shared by the LCD instruction executor.
// Assumes nothing of its surroundings.
`default_nettype none
package lcdie_pkg;
  // RAM that data accesses go to, chosen by the last set address instruction.
  typedef enum logic {LCDIE_TEXT, LCDIE_GLYPH} lcdie_ram_t;
endpackage
`default_nettype wire

/* File: hw/lcdie_core.sv */
// Instruction execution core of a character LCD controller, APB slave.
// Assumes an APB master on ref_clk_i and a display scanner that polls positions.
//
// Notes on behaviour
// - Blink bit alternates cursor character with full block, period clock/104448.
// - Shift moves cursor or display one step, never touching RAM.
// - Two-line cursor past a line end continues on the next line.
// - Display shift moves all lines together; no wrap between lines.
// - Display shift keeps the address counter; cursor shift steps it.
// - Width bit 1 takes whole bytes; 0 takes two nibbles on upper lines.
// - First 4-bit function set sees pulled-up low lines; host repeats it.
// - Function set over the serial path forces the width bit to 1.
// - Line bit 0 gives one line of 24; 1 gives two lines of 12.
// - Single-line bit gives mux 1:9, rows 1-8 and 17, line two hidden.
// - Extended bit selects the extended instruction set instead of standard.
// - Set glyph address loads counter bits 5:0 only and selects glyph RAM.
// - Status read gives busy and counter; busy blocks the next instruction.
// - Data write stores into the chosen RAM, then steps the counter.
// - Glyph RAM writes keep only the low five bits.
// - Data read shows the latch, then steps counter and reloads latch.
// - Only set address and data read update the read latch.
// - Glyph RAM bits drive 120 icons, 1 on and 0 off.
// - Glyph characters 0-2 give even-phase icons, 4-6 odd-phase with icon blink.
// - Even phase shows cursor as block; odd phase normal, icons follow.
// - Step bit 1 increments the counter after each access, 0 decrements.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lcdie_defines.svh"
module lcdie_core #(
  parameter int unsigned BLINK_DIV = `LCDIE_BLINK_DIV
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Display scan
  input wire logic [4:0] disp_pos_i,
  input wire logic disp_line_i,
  output logic [7:0] disp_code_o,
  output logic disp_block_o,
  output logic [17:0] row_enable_o,
  output logic two_line_o,
  output logic [119:0] icon_o
);

  // ==========================================================================
  // State
  logic [6:0] address_counter;
  logic [7:0] read_latch;
  logic [7:0] text_ram [128];
  logic [4:0] glyph_ram [128];
  lcdie_pkg::lcdie_ram_t ram_sel;
  logic bus_width_select;
  logic lines_select;
  logic single_line_select;
  logic ext_select;
  logic step_up;
  logic blink_en;
  logic icon_flash_select;
  logic serial_path;
  logic low_pullup;
  logic [3:0] busy_cnt;
  logic busy_indicator;
  logic [3:0] wr_hi;
  logic wr_half;
  logic rd_half;
  logic reload_q;
  logic [6:0] shift_ofs;
  logic [16:0] blink_cnt;
  logic blink_odd;

  // ==========================================================================
  // Bus decode
  logic acc;
  logic setup;
  logic hit_instr;
  logic hit_data;
  logic hit_ctrl;
  logic hit_mode;
  logic mapped;
  logic [7:0] in_byte;
  logic byte_done;
  logic nib_step;
  logic exec;
  logic wr_data;
  logic rd_done;
  logic set_text;
  logic set_glyph;
  logic fn_set;
  logic shift_cmd;
  logic entry_cmd;
  logic disp_cmd;
  logic icon_cmd;
  logic two_line;
  logic [7:0] stat_byte;
  logic [7:0] sel_byte;
  logic [31:0] next_prdata;

  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i;
  assign pready_o = 1'b1;

  always_comb
  begin
    hit_instr = 1'b0;
    hit_data = 1'b0;
    hit_ctrl = 1'b0;
    hit_mode = 1'b0;
    if (paddr_i == `LCDIE_OFS_INSTR)
      hit_instr = 1'b1;
    else if (paddr_i == `LCDIE_OFS_DATA)
      hit_data = 1'b1;
    else if (paddr_i == `LCDIE_OFS_CTRL)
      hit_ctrl = 1'b1;
    else if (paddr_i == `LCDIE_OFS_MODE)
      hit_mode = 1'b1;
  end

  assign mapped = hit_instr | hit_data | hit_ctrl | hit_mode;
  assign pslverr_o = acc & ~mapped;
  assign two_line = lines_select | single_line_select;

  // Instruction and data writes while busy are dropped whole, including a first nibble.
  assign nib_step = acc & pwrite_i & (hit_instr | hit_data) & ~busy_indicator;

  always_comb
  begin
    in_byte = pwdata_i[7:0];
    byte_done = 1'b0;
    if (nib_step)
    begin
      if (bus_width_select)
      begin
        byte_done = 1'b1;
        if (low_pullup)
          in_byte = {pwdata_i[7:4], 4'hF};
      end
      else
      begin
        byte_done = wr_half;
        in_byte = {wr_hi, pwdata_i[7:4]};
      end
    end
  end

  assign exec = byte_done & hit_instr;
  assign wr_data = byte_done & hit_data;
  assign set_text = exec & ~ext_select & in_byte[7];
  assign set_glyph = exec & ~ext_select & (in_byte[7:6] == 2'b01);
  assign fn_set = exec & (in_byte[7:5] == 3'b001);
  assign shift_cmd = exec & ~ext_select & (in_byte[7:4] == 4'b0001);
  assign disp_cmd = exec & ~ext_select & (in_byte[7:3] == 5'b00001);
  assign icon_cmd = exec & ext_select & (in_byte[7:3] == 5'b00001);
  assign entry_cmd = exec & ~ext_select & (in_byte[7:2] == 6'b000001);
  assign rd_done = acc & ~pwrite_i & hit_data & ~busy_indicator
                   & (bus_width_select | rd_half);

  // ==========================================================================
  // Counter step with line wrap
  function automatic logic [6:0] lcdie_step(input logic [6:0] a, input logic up,
                                            input logic glyph, input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (!glyph && two)
    begin
      if (up && a == `LCDIE_L1_END)
        r = `LCDIE_L2_START;
      else if (up && a == `LCDIE_L2_END)
        r = 7'h00;
      else if (!up && a == `LCDIE_L2_START)
        r = `LCDIE_L1_END;
      else if (!up && a == 7'h00)
        r = `LCDIE_L2_END;
    end
    else if (!glyph)
    begin
      if (up && a == `LCDIE_ONE_END)
        r = 7'h00;
      else if (!up && a == 7'h00)
        r = `LCDIE_ONE_END;
    end
    return r;
  endfunction

  // ==========================================================================
  // Nibble phases
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_hi <= 4'h0;
      wr_half <= 1'b0;
    end
    else if (fn_set)
      wr_half <= 1'b0;
    else if (nib_step && !bus_width_select)
    begin
      wr_hi <= pwdata_i[7:4];
      wr_half <= ~wr_half;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rd_half <= 1'b0;
    else if (bus_width_select)
      rd_half <= 1'b0;
    else if (acc && !pwrite_i && (hit_instr || hit_data))
      rd_half <= ~rd_half;
  end

  // ==========================================================================
  // Mode bits
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bus_width_select <= `LCDIE_RST_WIDTH;
      lines_select <= 1'b0;
      single_line_select <= 1'b0;
      ext_select <= 1'b0;
    end
    else if (fn_set)
    begin
      bus_width_select <= serial_path | in_byte[`LCDIE_FS_WIDTH];
      lines_select <= in_byte[`LCDIE_FS_LINES];
      single_line_select <= in_byte[`LCDIE_FS_SINGLE];
      ext_select <= in_byte[`LCDIE_FS_EXT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      step_up <= `LCDIE_RST_STEP;
      blink_en <= 1'b0;
      icon_flash_select <= 1'b0;
    end
    else if (entry_cmd)
      step_up <= in_byte[`LCDIE_EM_STEP];
    else if (disp_cmd)
      blink_en <= in_byte[`LCDIE_DC_BLINK];
    else if (icon_cmd)
      icon_flash_select <= in_byte[`LCDIE_IC_ICONF];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_path <= 1'b0;
      low_pullup <= 1'b0;
    end
    else if (acc && pwrite_i && hit_ctrl)
    begin
      serial_path <= pwdata_i[`LCDIE_CTRL_SERIAL];
      low_pullup <= pwdata_i[`LCDIE_CTRL_PULLUP];
    end
  end

  // ==========================================================================
  // Busy timer
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      busy_cnt <= 4'h0;
    else if (exec || wr_data || rd_done)
      busy_cnt <= `LCDIE_EXEC_CYC;
    else if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
  end

  assign busy_indicator = (busy_cnt != 4'h0);

  // ==========================================================================
  // Address counter, RAM select and display offset
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      address_counter <= 7'h00;
      ram_sel <= lcdie_pkg::LCDIE_TEXT;
    end
    else if (set_text)
    begin
      address_counter <= in_byte[6:0];
      ram_sel <= lcdie_pkg::LCDIE_TEXT;
    end
    else if (set_glyph)
    begin
      address_counter[5:0] <= in_byte[5:0];
      ram_sel <= lcdie_pkg::LCDIE_GLYPH;
    end
    else if (wr_data || rd_done)
      address_counter <= lcdie_step(address_counter, step_up,
                                    ram_sel == lcdie_pkg::LCDIE_GLYPH, two_line);
    else if (shift_cmd && !in_byte[`LCDIE_SH_DISP])
      address_counter <= lcdie_step(address_counter, in_byte[`LCDIE_SH_RIGHT],
                                    1'b0, two_line);
  end

  // Offset runs over the whole text RAM; two-line view folds it per line.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      shift_ofs <= 7'h00;
    else if (shift_cmd && in_byte[`LCDIE_SH_DISP])
    begin
      if (in_byte[`LCDIE_SH_RIGHT])
        shift_ofs <= (shift_ofs == 7'h00) ? `LCDIE_RAM_LEN - 7'd1 : shift_ofs - 7'd1;
      else
        shift_ofs <= (shift_ofs == `LCDIE_RAM_LEN - 7'd1) ? 7'h00 : shift_ofs + 7'd1;
    end
  end

  // ==========================================================================
  // RAM storage; shifts never reach these write enables
  for (genvar i = 0; i < 128; i++)
  begin : g_ram
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        text_ram[i] <= `LCDIE_RST_TEXT;
        glyph_ram[i] <= 5'h00;
      end
      else if (wr_data && address_counter == 7'(i))
      begin
        if (ram_sel == lcdie_pkg::LCDIE_GLYPH)
          glyph_ram[i] <= in_byte[4:0];
        else
          text_ram[i] <= in_byte;
      end
    end
  end

  // ==========================================================================
  // Read latch
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reload_q <= 1'b0;
    else
      reload_q <= set_text | set_glyph | rd_done;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      read_latch <= 8'h00;
    else if (reload_q)
    begin
      if (ram_sel == lcdie_pkg::LCDIE_GLYPH)
        read_latch <= {3'b000, glyph_ram[address_counter]};
      else
        read_latch <= text_ram[address_counter];
    end
  end

  // ==========================================================================
  // Read data, captured in the setup cycle
  always_comb
  begin
    stat_byte = {busy_indicator, address_counter};
    sel_byte = hit_instr ? stat_byte : read_latch;
    next_prdata = 32'h0000_0000;
    if (hit_instr || hit_data)
    begin
      if (bus_width_select)
        next_prdata[7:0] = sel_byte;
      else if (rd_half)
        next_prdata[7:4] = sel_byte[3:0];
      else
        next_prdata[7:4] = sel_byte[7:4];
    end
    else if (hit_ctrl)
    begin
      next_prdata[`LCDIE_CTRL_SERIAL] = serial_path;
      next_prdata[`LCDIE_CTRL_PULLUP] = low_pullup;
    end
    else if (hit_mode)
    begin
      next_prdata[`LCDIE_MODE_WIDTH] = bus_width_select;
      next_prdata[`LCDIE_MODE_LINES] = lines_select;
      next_prdata[`LCDIE_MODE_SINGLE] = single_line_select;
      next_prdata[`LCDIE_MODE_EXT] = ext_select;
      next_prdata[`LCDIE_MODE_STEP] = step_up;
      next_prdata[`LCDIE_MODE_BLINK] = blink_en;
      next_prdata[`LCDIE_MODE_ICONF] = icon_flash_select;
      next_prdata[`LCDIE_MODE_PHASE] = blink_odd;
      next_prdata[`LCDIE_MODE_GLYPH] = (ram_sel == lcdie_pkg::LCDIE_GLYPH);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      prdata_o <= 32'h0000_0000;
    else if (setup)
      prdata_o <= next_prdata;
  end

  // ==========================================================================
  // Blink phase: even half shows the block, odd half the glyph
  localparam logic [16:0] BLINK_HALF = 17'(BLINK_DIV / 2);

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blink_cnt <= 17'h00000;
      blink_odd <= 1'b0;
    end
    else if (blink_cnt == BLINK_HALF - 17'h00001)
    begin
      blink_cnt <= 17'h00000;
      blink_odd <= ~blink_odd;
    end
    else
      blink_cnt <= blink_cnt + 17'h00001;
  end

  // ==========================================================================
  // Display scan
  logic [6:0] line_ofs;
  logic [6:0] col_sum;
  logic [6:0] scan_addr;

  always_comb
  begin
    line_ofs = (shift_ofs >= `LCDIE_LINE_LEN) ? shift_ofs - `LCDIE_LINE_LEN : shift_ofs;
    if (two_line)
    begin
      col_sum = {2'b00, disp_pos_i} + line_ofs;
      if (col_sum >= `LCDIE_LINE_LEN)
        col_sum = col_sum - `LCDIE_LINE_LEN;
      scan_addr = disp_line_i ? `LCDIE_L2_START + col_sum : col_sum;
    end
    else
    begin
      col_sum = {2'b00, disp_pos_i} + shift_ofs;
      if (col_sum >= `LCDIE_RAM_LEN)
        col_sum = col_sum - `LCDIE_RAM_LEN;
      scan_addr = col_sum;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      disp_code_o <= `LCDIE_RST_TEXT;
      disp_block_o <= 1'b0;
    end
    else
    begin
      if (single_line_select && disp_line_i)
        disp_code_o <= `LCDIE_RST_TEXT;
      else
        disp_code_o <= text_ram[scan_addr];
      disp_block_o <= blink_en & ~blink_odd & (scan_addr == address_counter)
                      & (ram_sel == lcdie_pkg::LCDIE_TEXT)
                      & ~(single_line_select & disp_line_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      row_enable_o <= `LCDIE_ROWS_ALL;
      two_line_o <= 1'b0;
    end
    else
    begin
      row_enable_o <= single_line_select ? `LCDIE_ROWS_MUX9 : `LCDIE_ROWS_ALL;
      two_line_o <= lines_select & ~single_line_select;
    end
  end

  // ==========================================================================
  // Icons: five icons per glyph row, leftmost icon in the top data bit
  logic odd_set;

  assign odd_set = icon_flash_select & blink_odd;

  for (genvar i = 0; i < 120; i++)
  begin : g_icon
    localparam logic [6:0] ROW_ADDR = 7'(i / 5);
    localparam int BIT_POS = 4 - (i % 5);
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
        icon_o[i] <= 1'b0;
      else
        icon_o[i] <= glyph_ram[ROW_ADDR | (odd_set ? `LCDIE_ODD_BASE : 7'h00)][BIT_POS];
    end
  end

endmodule
`default_nettype wire

/* File: sim/lcdie_checker.sv */
// Port checker of lcdie_core, bound into every instance of it.
// Assumes a zero-wait APB slave and a scanner that holds its position inputs.
`timescale 1ns/100ps
`default_nettype none
module lcdie_checker #(
  parameter int unsigned BLINK_DIV = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Display scan
  input wire logic [4:0] disp_pos_i,
  input wire logic disp_line_i,
  input wire logic [7:0] disp_code_o,
  input wire logic disp_block_o,
  input wire logic [17:0] row_enable_o,
  input wire logic two_line_o,
  input wire logic [119:0] icon_o
);
  logic [15:0] run;
  logic mapped;
  logic rd;
  assign mapped = (paddr_i[11:4] == 8'h00) && (paddr_i[1:0] == 2'h0);
  assign rd = psel_i && penable_i && !pwrite_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Length of the current run of block display.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      run <= 16'h0;
    else
      run <= disp_block_o ? run + 16'h1 : 16'h0;
  end
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence
  AST_READY: assert property (s_access |-> pready_o)
    else $error("pready low in access");
  AST_SLVERR: assert property (s_access |-> pslverr_o == !mapped)
    else $error("pslverr wrong");
  AST_RD_HOLD: assert property (s_setup ##1 s_access |=> $stable(prdata_o))
    else $error("read data moved in access");
  AST_UNMAP_ZERO: assert property (rd && !mapped |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS_WIDTH: assert property (rd && paddr_i == 12'h000
    |-> prdata_o[31:8] == 24'h0)
    else $error("status read too wide");
  AST_LATCH_WIDTH: assert property (rd && paddr_i == 12'h004
    |-> prdata_o[31:8] == 24'h0)
    else $error("data read too wide");
  AST_ROWS: assert property (row_enable_o == 18'h3FFFF || row_enable_o == 18'h100FF)
    else $error("row enable pattern wrong");
  AST_TWO_ROWS: assert property (two_line_o |-> row_enable_o == 18'h3FFFF)
    else $error("two lines with single-line rows");
  AST_HIDDEN: assert property (row_enable_o == 18'h100FF && $past(disp_line_i)
    |-> disp_code_o == 8'h20)
    else $error("second line shown in single-line");
  AST_BLINK_HALF: assert property (run <= BLINK_DIV / 2)
    else $error("block phase too long");
endmodule
bind lcdie_core lcdie_checker #(.BLINK_DIV(BLINK_DIV)) u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .disp_pos_i(disp_pos_i),
  .disp_line_i(disp_line_i), .disp_code_o(disp_code_o), .disp_block_o(disp_block_o),
  .row_enable_o(row_enable_o), .two_line_o(two_line_o), .icon_o(icon_o)
);
`default_nettype wire

/* File: sim/lcdie_host.sv */
// Host model: APB master tasks used by software to reach the executor.
// Assumes the bench calls its tasks and owns the clock.
`timescale 1ns/100ps
`default_nettype none
module lcdie_host (
  // Clock
  input wire logic ref_clk_i,
  // APB master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i
);
  logic nib = 1'b0;
  int hung = 0;
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge ref_clk_i);
      if (pready_i === 1'b1)
        break;
    end
    if (n == 16)
      hung++;
    q = prdata_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Polls the status word until busy clears; in nibble mode reads come in pairs.
  task automatic wait_idle();
    logic [31:0] q;
    logic [31:0] r;
    int n;
    for (n = 0; n < 32; n++)
    begin
      xfer(1'b0, 12'h000, 32'h0, q);
      if (nib)
        xfer(1'b0, 12'h000, 32'h0, r);
      if (q[7] === 1'b0)
        break;
    end
    if (n == 32)
      hung++;
  endtask
  task automatic send(input logic [11:0] a, input logic [7:0] b);
    logic [31:0] q;
    wait_idle();
    if (nib)
    begin
      xfer(1'b1, a, {24'h0, b[7:4], 4'h0}, q);
      xfer(1'b1, a, {24'h0, b[3:0], 4'h0}, q);
    end
    else
      xfer(1'b1, a, {24'h0, b}, q);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench of lcdie_core: instruction sequences with expected values.
// Assumes lcdie_host as APB master and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk_i;
  logic nrst_i;
  logic psel, penable, pwrite, pready, pslverr, disp_line, disp_block, two_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] disp_pos;
  logic [7:0] disp_code;
  logic [17:0] rows;
  logic [119:0] icon;
  int miscompares = 0;
  int checks = 0;
  int na, nb, nc;
  lcdie_core #(.BLINK_DIV(8)) dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .disp_pos_i(disp_pos), .disp_line_i(disp_line),
    .disp_code_o(disp_code), .disp_block_o(disp_block), .row_enable_o(rows),
    .two_line_o(two_line), .icon_o(icon)
  );
  lcdie_host host (
    .ref_clk_i(ref_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready), .prdata_i(prdata)
  );
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic close_out();
    miscompares += host.hung;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Reads a register once idle; the blink phase bit of the mode word is masked.
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    host.wait_idle();
    host.xfer(1'b0, a, 32'h0, q);
    if (a == 12'h00C)
      q[7] = 1'b0;
    chk(s, e, q);
  endtask
  initial
  begin
    repeat (30000) @(posedge ref_clk_i);
    miscompares++;
    close_out();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    nrst_i = 1'b0;
    disp_pos = 5'h00;
    disp_line = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rdc("mode", 12'h00C, 32'h11);
    rdc("status", 12'h000, 32'h0);
    rdc("unmapped", 12'h010, 32'h0);
    host.send(12'h000, 8'hBF);
    host.send(12'h004, 8'h41);
    rdc("carry", 12'h000, 32'h40);
    host.send(12'h000, 8'h45);
    rdc("glyph addr", 12'h000, 32'h45);
    rdc("glyph sel", 12'h00C, 32'h111);
    host.send(12'h000, 8'h80);
    host.send(12'h000, 8'h40);
    host.send(12'h004, 8'hF3);
    host.wait_idle();
    chk("icon", 32'h19, {27'h0, icon[4:0]});
    host.send(12'h000, 8'h40);
    host.send(12'h000, 8'h14);
    rdc("cursor", 12'h000, 32'h01);
    rdc("latch", 12'h004, 32'h13);
    rdc("step", 12'h000, 32'h02);
    host.send(12'h004, 8'h0A);
    rdc("kept", 12'h004, 32'h00);
    host.send(12'h000, 8'h04);
    host.send(12'h000, 8'h85);
    host.send(12'h004, 8'h42);
    rdc("down", 12'h000, 32'h04);
    host.send(12'h000, 8'h06);
    host.send(12'h000, 8'h18);
    host.send(12'h000, 8'h1C);
    rdc("disp shift", 12'h000, 32'h04);
    host.send(12'h000, 8'h90);
    host.xfer(1'b0, 12'h000, 32'h0, q);
    chk("busy", 32'h1, {31'h0, q[7]});
    host.send(12'h000, 8'h91);
    host.xfer(1'b1, 12'h000, 32'h92, q);
    rdc("dropped", 12'h000, 32'h11);
    host.xfer(1'b1, 12'h008, 32'h2, q);
    host.send(12'h000, 8'h20);
    // The pulled-up function set leaves the device in nibble mode: status reads pair up.
    host.nib = 1'b1;
    rdc("pulled", 12'h00C, 32'h1E);
    disp_line <= 1'b1;
    chk("rows", 32'h100FF, {14'h0, rows});
    host.send(12'h000, 8'h24);
    rdc("nibble", 12'h00C, 32'h12);
    chk("two line", 32'h1, {31'h0, two_line});
    host.send(12'h000, 8'hC5);
    host.wait_idle();
    host.xfer(1'b0, 12'h000, 32'h0, q);
    chk("upper", 32'h4, {28'h0, q[7:4]});
    host.xfer(1'b0, 12'h000, 32'h0, q);
    chk("lower", 32'h5, {28'h0, q[7:4]});
    host.xfer(1'b1, 12'h008, 32'h1, q);
    host.send(12'h000, 8'h20);
    host.nib = 1'b0;
    rdc("serial", 12'h00C, 32'h11);
    host.xfer(1'b1, 12'h008, 32'h0, q);
    host.send(12'h000, 8'h31);
    host.send(12'h000, 8'h0A);
    rdc("ext", 12'h00C, 32'h59);
    host.send(12'h000, 8'h30);
    host.send(12'h000, 8'h09);
    host.send(12'h000, 8'h80);
    host.send(12'h000, 8'h60);
    host.send(12'h004, 8'h1F);
    host.send(12'h000, 8'h80);
    host.wait_idle();
    disp_line <= 1'b0;
    na = 0;
    nb = 0;
    nc = 0;
    repeat (16)
    begin
      @(negedge ref_clk_i);
      na += (icon[4:0] === 5'h19);
      nb += (icon[4:0] === 5'h1F);
      nc += (disp_block === 1'b1);
    end
    chk("even icons", 32'd8, na);
    chk("odd icons", 32'd8, nb);
    chk("block", 32'd8, nc);
    host.send(12'h000, 8'h18);
    disp_pos <= 5'h04;
    repeat (2) @(negedge ref_clk_i);
    chk("scan", 32'h42, {24'h0, disp_code});
    close_out();
  end
endmodule
`default_nettype wire
